// *** hdl/emcr_pkg.sv ***
// constants shared by the energy meter configuration register bank
package emcr_pkg;
  // register addresses on the meter address pointer
  localparam logic [6:0] ADDR_MODE_A = 7'h0b;
  localparam logic [6:0] ADDR_MODE_B = 7'h0c;
  localparam logic [6:0] ADDR_REACT_DIV = 7'h25;
  localparam logic [6:0] ADDR_APPAR_DIV = 7'h26;
  localparam logic [6:0] ADDR_PA_NUM = 7'h27;
  localparam logic [6:0] ADDR_PA_DEN = 7'h28;
  localparam logic [6:0] ADDR_PB_NUM = 7'h29;
  localparam logic [6:0] ADDR_PB_DEN = 7'h2a;
  localparam logic [6:0] ADDR_RSVD_A = 7'h3b;
  localparam logic [6:0] ADDR_RSVD_B = 7'h3c;
  localparam logic [6:0] ADDR_CAL_MODE = 7'h3d;
  localparam logic [6:0] ADDR_RSVD_C = 7'h3e;
  localparam logic [6:0] ADDR_RSVD_D = 7'h3f;
  // reset values
  localparam logic [7:0] RST_MODE_A = 8'h06;
  localparam logic [7:0] RST_MODE_B = 8'h40;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [15:0] RST_NUM = 16'h0000;
  localparam logic [15:0] RST_DEN = 16'h003f;
  localparam logic [7:0] RST_RSVD8 = 8'h00;
  localparam logic [15:0] RST_RSVD_B = 16'h0300;
  localparam logic [7:0] RST_CAL = 8'h00;
  // mode a bit positions
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_ZX_FILT_OFF = 6;
  localparam int BIT_INTEG_ON = 5;
  localparam int BIT_CH_SWAP = 4;
  localparam int BIT_PWR_OFF = 3;
  localparam int BIT_PB_OFF = 2;
  localparam int BIT_PA_OFF = 1;
  localparam int BIT_HP_OFF = 0;
  // mode b field positions
  localparam int PB_SRC_HI = 7;
  localparam int PB_SRC_LO = 6;
  localparam int PA_SRC_HI = 5;
  localparam int PA_SRC_LO = 4;
  localparam int BIT_APP_RMS = 3;
  localparam int BIT_RMS_ZX = 2;
  // source codes seen by the pulse generators
  localparam logic [1:0] SRC_ACTIVE = 2'h0;
  localparam logic [1:0] SRC_REACTIVE = 2'h1;
  localparam logic [1:0] SRC_APPARENT = 2'h2;
  localparam logic [1:0] SRC_RMS_CURRENT = 2'h3;
  localparam logic [15:0] RD_ZERO = 16'h0000;
endpackage : emcr_pkg

// *** hdl/emcr_regs.sv ***
// configuration registers and mode decode of the energy meter
`timescale 1ns/1ps
module emcr_regs
  import emcr_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [6:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output logic meas_reset_out,
  output logic zx_filter_bypass_out,
  output logic integrator_on_out,
  output logic channel_swap_out,
  output logic converter_power_off_out,
  output logic highpass_bypass_out,
  output logic pulse_a_enable_out,
  output logic pulse_b_enable_out,
  output logic [1:0] pulse_a_quantity_out,
  output logic [1:0] pulse_b_quantity_out,
  output logic apparent_accum_rms_out,
  output logic rms_on_zero_cross_out,
  output logic [7:0] reactive_energy_divider_out,
  output logic [7:0] apparent_energy_divider_out,
  output logic [15:0] pulse_a_numerator_out,
  output logic [15:0] pulse_a_denominator_out,
  output logic [15:0] pulse_b_numerator_out,
  output logic [15:0] pulse_b_denominator_out,
  output logic [7:0] calibration_mode_out
);
  typedef struct packed {
    logic [7:0] meter_mode_a;
    logic [7:0] meter_mode_b;
    logic [7:0] reactive_energy_divider;
    logic [7:0] apparent_energy_divider;
    logic [15:0] pulse_a_numerator;
    logic [15:0] pulse_a_denominator;
    logic [15:0] pulse_b_numerator;
    logic [15:0] pulse_b_denominator;
    logic [7:0] reserved_a;
    logic [15:0] reserved_b;
    logic [7:0] calibration_mode;
    logic [7:0] reserved_c;
    logic [7:0] reserved_d;
    logic [15:0] rdata;
    logic rvalid;
    logic meas_reset;
    logic pulse_a_en;
    logic pulse_b_en;
    logic [1:0] pulse_a_q;
    logic [1:0] pulse_b_q;
  } emcr_state_s;

  emcr_state_s st;
  emcr_state_s next_st;

  // quantity a pulse output follows, given its 2-bit source field
  function automatic logic [1:0] emcr_quantity(input logic [1:0] src, input logic app_rms);
    logic [1:0] q;
    q = src;
    if (src[1])
    begin
      // one shared bit picks for both outputs, so they never mix va and rms
      q = app_rms ? SRC_RMS_CURRENT : SRC_APPARENT;
    end
    return q;
  endfunction : emcr_quantity

  // default image of every register, used by hard and soft reset
  function automatic emcr_state_s emcr_defaults();
    emcr_state_s d;
    d.meter_mode_a = RST_MODE_A;
    d.meter_mode_b = RST_MODE_B;
    d.reactive_energy_divider = RST_DIV;
    d.apparent_energy_divider = RST_DIV;
    d.pulse_a_numerator = RST_NUM;
    d.pulse_a_denominator = RST_DEN;
    d.pulse_b_numerator = RST_NUM;
    d.pulse_b_denominator = RST_DEN;
    d.reserved_a = RST_RSVD8;
    d.reserved_b = RST_RSVD_B;
    d.calibration_mode = RST_CAL;
    d.reserved_c = RST_RSVD8;
    d.reserved_d = RST_RSVD8;
    d.rdata = RD_ZERO;
    d.rvalid = 1'b0;
    d.meas_reset = 1'b0;
    // decoded pulse controls follow the mode defaults
    d.pulse_a_en = ~RST_MODE_A[BIT_PA_OFF];
    d.pulse_b_en = ~RST_MODE_A[BIT_PB_OFF];
    d.pulse_a_q = emcr_quantity(RST_MODE_B[PA_SRC_HI:PA_SRC_LO], RST_MODE_B[BIT_APP_RMS]);
    d.pulse_b_q = emcr_quantity(RST_MODE_B[PB_SRC_HI:PB_SRC_LO], RST_MODE_B[BIT_APP_RMS]);
    return d;
  endfunction : emcr_defaults

  // register writes, soft reset and read mux
  always_comb
  begin
    next_st = st;
    next_st.meas_reset = 1'b0;
    next_st.rvalid = rd_in;
    if (wr_in)
    begin
      case (addr_in)
        ADDR_MODE_A: next_st.meter_mode_a = wdata_in[7:0];
        ADDR_MODE_B: next_st.meter_mode_b = wdata_in[7:0];
        ADDR_REACT_DIV: next_st.reactive_energy_divider = wdata_in[7:0];
        ADDR_APPAR_DIV: next_st.apparent_energy_divider = wdata_in[7:0];
        ADDR_PA_NUM: next_st.pulse_a_numerator = wdata_in;
        ADDR_PA_DEN: next_st.pulse_a_denominator = wdata_in;
        ADDR_PB_NUM: next_st.pulse_b_numerator = wdata_in;
        ADDR_PB_DEN: next_st.pulse_b_denominator = wdata_in;
        // reserved entries are stored as written; keeping defaults is software's job
        ADDR_RSVD_A: next_st.reserved_a = wdata_in[7:0];
        ADDR_RSVD_B: next_st.reserved_b = wdata_in;
        ADDR_CAL_MODE: next_st.calibration_mode = wdata_in[7:0];
        ADDR_RSVD_C: next_st.reserved_c = wdata_in[7:0];
        ADDR_RSVD_D: next_st.reserved_d = wdata_in[7:0];
        default: next_st.meas_reset = 1'b0;
      endcase
      // soft reset bit self-clears: every register returns to default
      if (addr_in == ADDR_MODE_A && wdata_in[BIT_SOFT_RESET])
      begin
        next_st = emcr_defaults();
        next_st.meas_reset = 1'b1;
      end
    end
    // pulse controls decoded from the next mode image, so they are flops yet land with the write
    next_st.pulse_a_en = ~next_st.meter_mode_a[BIT_PA_OFF];
    next_st.pulse_b_en = ~next_st.meter_mode_a[BIT_PB_OFF];
    next_st.pulse_a_q = emcr_quantity(next_st.meter_mode_b[PA_SRC_HI:PA_SRC_LO],
      next_st.meter_mode_b[BIT_APP_RMS]);
    next_st.pulse_b_q = emcr_quantity(next_st.meter_mode_b[PB_SRC_HI:PB_SRC_LO],
      next_st.meter_mode_b[BIT_APP_RMS]);
    // read data registered one cycle after the strobe
    if (rd_in)
    begin
      case (addr_in)
        ADDR_MODE_A: next_st.rdata = {8'h00, st.meter_mode_a};
        ADDR_MODE_B: next_st.rdata = {8'h00, st.meter_mode_b};
        ADDR_REACT_DIV: next_st.rdata = {8'h00, st.reactive_energy_divider};
        ADDR_APPAR_DIV: next_st.rdata = {8'h00, st.apparent_energy_divider};
        ADDR_PA_NUM: next_st.rdata = st.pulse_a_numerator;
        ADDR_PA_DEN: next_st.rdata = st.pulse_a_denominator;
        ADDR_PB_NUM: next_st.rdata = st.pulse_b_numerator;
        ADDR_PB_DEN: next_st.rdata = st.pulse_b_denominator;
        ADDR_RSVD_A: next_st.rdata = {8'h00, st.reserved_a};
        ADDR_RSVD_B: next_st.rdata = st.reserved_b;
        ADDR_CAL_MODE: next_st.rdata = {8'h00, st.calibration_mode};
        ADDR_RSVD_C: next_st.rdata = {8'h00, st.reserved_c};
        ADDR_RSVD_D: next_st.rdata = {8'h00, st.reserved_d};
        default: next_st.rdata = RD_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st <= emcr_defaults();
    end
    else
    begin
      st <= next_st;
    end
  end

  // decoded controls, all taken straight from the state flops
  assign rdata_out = st.rdata;
  assign rvalid_out = st.rvalid;
  assign meas_reset_out = st.meas_reset;
  assign zx_filter_bypass_out = st.meter_mode_a[BIT_ZX_FILT_OFF];
  assign integrator_on_out = st.meter_mode_a[BIT_INTEG_ON];
  assign channel_swap_out = st.meter_mode_a[BIT_CH_SWAP];
  assign converter_power_off_out = st.meter_mode_a[BIT_PWR_OFF];
  assign pulse_b_enable_out = st.pulse_b_en;
  assign pulse_a_enable_out = st.pulse_a_en;
  assign highpass_bypass_out = st.meter_mode_a[BIT_HP_OFF];
  assign pulse_b_quantity_out = st.pulse_b_q;
  assign pulse_a_quantity_out = st.pulse_a_q;
  assign apparent_accum_rms_out = st.meter_mode_b[BIT_APP_RMS];
  assign rms_on_zero_cross_out = st.meter_mode_b[BIT_RMS_ZX];
  assign reactive_energy_divider_out = st.reactive_energy_divider;
  assign apparent_energy_divider_out = st.apparent_energy_divider;
  assign pulse_a_numerator_out = st.pulse_a_numerator;
  assign pulse_a_denominator_out = st.pulse_a_denominator;
  assign pulse_b_numerator_out = st.pulse_b_numerator;
  assign pulse_b_denominator_out = st.pulse_b_denominator;
  assign calibration_mode_out = st.calibration_mode;
endmodule : emcr_regs

// *** testbench/emcr_regs_props.sv ***
// assertion checker for the energy meter configuration registers
`timescale 1ns/1ps
module emcr_regs_props
  import emcr_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [6:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] wdata_in,
  input wire logic rvalid_out,
  input wire logic meas_reset_out,
  input wire logic zx_filter_bypass_out,
  input wire logic integrator_on_out,
  input wire logic channel_swap_out,
  input wire logic converter_power_off_out,
  input wire logic highpass_bypass_out,
  input wire logic pulse_a_enable_out,
  input wire logic pulse_b_enable_out,
  input wire logic [1:0] pulse_a_quantity_out,
  input wire logic [1:0] pulse_b_quantity_out,
  input wire logic apparent_accum_rms_out,
  input wire logic [15:0] pulse_a_numerator_out,
  input wire logic [15:0] pulse_a_denominator_out,
  input wire logic [7:0] reactive_energy_divider_out,
  input wire logic [7:0] apparent_energy_divider_out,
  input wire logic [15:0] pulse_b_numerator_out,
  input wire logic [15:0] pulse_b_denominator_out,
  input wire logic [7:0] calibration_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic wa;
  // mode a write seen at the port
  assign wa = wr_in && addr_in == ADDR_MODE_A;
  property p_rv; rvalid_out == $past(rd_in); endproperty
  a_rv: assert property (p_rv) else $error("read valid misplaced");
  property p_sr; wa && wdata_in[7] |=> meas_reset_out && !pulse_a_enable_out && pulse_a_denominator_out == 16'h003f
    && pulse_b_quantity_out == 2'h1; endproperty
  a_sr: assert property (p_sr) else $error("soft reset lost");
  property p_mb; wa && !wdata_in[7] |=> {zx_filter_bypass_out, integrator_on_out, channel_swap_out,
    converter_power_off_out, highpass_bypass_out} == {$past(wdata_in[6:3]), $past(wdata_in[0])}; endproperty
  a_mb: assert property (p_mb) else $error("mode a levels wrong");
  property p_en; wa && !wdata_in[7] |=> pulse_a_enable_out != $past(wdata_in[1])
    && pulse_b_enable_out != $past(wdata_in[2]); endproperty
  a_en: assert property (p_en) else $error("pulse enable wrong");
  property p_q; pulse_a_quantity_out[1] |-> pulse_a_quantity_out[0] == apparent_accum_rms_out; endproperty
  a_q: assert property (p_q) else $error("apparent or rms mismatch");
  property p_mix; pulse_a_quantity_out[1] && pulse_b_quantity_out[1] |-> pulse_a_quantity_out == pulse_b_quantity_out;
  endproperty
  a_mix: assert property (p_mix) else $error("mixed apparent and rms");
  property p_rst; $rose(arst_n_in) |-> pulse_b_quantity_out == 2'h1 && pulse_a_quantity_out == 2'h0
    && !pulse_b_enable_out; endproperty
  a_rst: assert property (p_rst) else $error("reset source wrong");
  property p_num; wr_in && addr_in == ADDR_PA_NUM |=> pulse_a_numerator_out == $past(wdata_in); endproperty
  a_num: assert property (p_num) else $error("numerator not taken");
  property p_pad; wr_in && addr_in == ADDR_PA_DEN |=> pulse_a_denominator_out == $past(wdata_in); endproperty
  a_pad: assert property (p_pad) else $error("pulse a denominator not taken");
  property p_pbn; wr_in && addr_in == ADDR_PB_NUM |=> pulse_b_numerator_out == $past(wdata_in); endproperty
  a_pbn: assert property (p_pbn) else $error("pulse b numerator not taken");
  property p_pbd; wr_in && addr_in == ADDR_PB_DEN |=> pulse_b_denominator_out == $past(wdata_in); endproperty
  a_pbd: assert property (p_pbd) else $error("pulse b denominator not taken");
  property p_rdv; wr_in && addr_in == ADDR_REACT_DIV |=>
    reactive_energy_divider_out == $past(wdata_in[7:0]); endproperty
  a_rdv: assert property (p_rdv) else $error("reactive divider not taken");
  property p_adv; wr_in && addr_in == ADDR_APPAR_DIV |=>
    apparent_energy_divider_out == $past(wdata_in[7:0]); endproperty
  a_adv: assert property (p_adv) else $error("apparent divider not taken");
  property p_cal; wr_in && addr_in == ADDR_CAL_MODE |=> calibration_mode_out == $past(wdata_in[7:0]); endproperty
  a_cal: assert property (p_cal) else $error("calibration mode not taken");
  c_sr: cover property (wa && wdata_in[7]);
  c_rms: cover property (pulse_a_quantity_out == SRC_RMS_CURRENT);
  c_rd: cover property (rvalid_out);
endmodule : emcr_regs_props
bind emcr_regs emcr_regs_props u_props (.clk_in, .arst_n_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rvalid_out,
  .meas_reset_out, .zx_filter_bypass_out, .integrator_on_out, .channel_swap_out, .converter_power_off_out,
  .highpass_bypass_out, .pulse_a_enable_out, .pulse_b_enable_out, .pulse_a_quantity_out, .pulse_b_quantity_out,
  .apparent_accum_rms_out, .pulse_a_numerator_out, .pulse_a_denominator_out, .reactive_energy_divider_out,
  .apparent_energy_divider_out, .pulse_b_numerator_out, .pulse_b_denominator_out, .calibration_mode_out);

// *** testbench/emcr_regs_tb.sv ***
// self-checking testbench for the energy meter configuration registers
`timescale 1ns/1ps
module emcr_regs_tb;
  import emcr_pkg::*;
  logic clk_in, arst_n_in, wr_in, rd_in, rvalid_out, zx;
  logic [6:0] addr_in;
  logic [15:0] wdata_in, rdata_out, r;
  logic [1:0] qa, qb, e;
  int fails, n_checks;
  logic [15:0] expq[$];
  logic [6:0] ad[13] = '{ADDR_MODE_A, ADDR_MODE_B, ADDR_REACT_DIV, ADDR_APPAR_DIV, ADDR_PA_NUM, ADDR_PA_DEN,
    ADDR_PB_NUM, ADDR_PB_DEN, ADDR_CAL_MODE, ADDR_RSVD_A, ADDR_RSVD_B, ADDR_RSVD_C, ADDR_RSVD_D};
  logic [15:0] df[13] = '{16'h0006, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h003f, 16'h0000, 16'h003f,
    16'h0000, 16'h0000, 16'h0300, 16'h0000, 16'h0000};
  emcr_regs u_dut (.clk_in, .arst_n_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out, .rvalid_out,
    .meas_reset_out(), .zx_filter_bypass_out(), .integrator_on_out(), .channel_swap_out(),
    .converter_power_off_out(), .highpass_bypass_out(), .pulse_a_enable_out(), .pulse_b_enable_out(),
    .pulse_a_quantity_out(qa), .pulse_b_quantity_out(qb), .apparent_accum_rms_out(),
    .rms_on_zero_cross_out(zx), .reactive_energy_divider_out(), .apparent_energy_divider_out(),
    .pulse_a_numerator_out(), .pulse_a_denominator_out(), .pulse_b_numerator_out(),
    .pulse_b_denominator_out(), .calibration_mode_out());
  // readable bits: 16 wide, 8 wide, soft reset bit never reads back
  function automatic logic [15:0] mk(input int i);
    return (i > 3 && i < 8) ? 16'hffff : (i == 0 ? 16'h007f : 16'h00ff);
  endfunction : mk
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one access, strobe held for a single edge; a read notes its expected data
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
    if (!w) expq.push_back(d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask : acc
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // sampled mid-cycle so the registered answer has settled
  always @(negedge clk_in)
    if (rvalid_out === 1'b1)
    begin
      if (expq.size() > 0)
        chk(rdata_out, expq.pop_front());
      else
        fails++;
    end
  initial
  begin
    void'($urandom(1569));
    {arst_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 13; i++) acc(1'b0, ad[i], df[i]);
    chk({12'h000, qa, qb}, 16'h0001);
    // reserved entries are never written, software keeps their defaults
    for (int i = 0; i < 9; i++)
    begin
      r = 16'($urandom());
      if (i == 0) r[7] = 1'b0;
      acc(1'b1, ad[i], r);
      acc(1'b0, ad[i], r & mk(i));
    end
    acc(1'b1, 7'h30, 16'hffff);
    acc(1'b0, 7'h30, 16'h0000);
    for (int c = 0; c < 8; c++)
    begin
      acc(1'b1, ADDR_MODE_B, {8'h00, 2'(c), 2'(c), c[2], c[0], 2'b00});
      e = c[1] ? {1'b1, c[2]} : 2'(c);
      chk({11'h000, zx, qa, qb}, {11'h000, c[0], e, e});
    end
    acc(1'b1, ADDR_PB_NUM, 16'h1234);
    acc(1'b1, ADDR_MODE_A, 16'h00f9);
    for (int i = 0; i < 13; i++) acc(1'b0, ad[i], df[i]);
    for (int k = 0; k < 10 && expq.size() > 0; k++) @(posedge clk_in);
    if (expq.size() > 0) fails++;
    close_out();
  end
endmodule : emcr_regs_tb
